// >>> timer16_edge_clear_freerun.v
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module timer16_edge_clear_freerun #(
  parameter DIV1 = `DIV_SEL1,
  parameter DIV2 = `DIV_SEL2,
  parameter DIV3 = `DIV_SEL3
) (
  input  wire        i_clk_sys,
  input  wire        i_nrst,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  input  wire        i_trigger_input_a,
  input  wire        i_trigger_input_b,
  output wire        o_timer_output,
  output reg         o_irq_request_a,
  output reg         o_irq_request_b
);
  // Software visible state, then internal output and change flags
  reg  [15:0] up_count_value;     // Live counter
  reg  [15:0] capture_compare_a;  // Capture/compare register A
  reg  [15:0] capture_compare_b;  // Capture/compare register B
  reg  [1:0]  op_mode;            // Operating mode field
  reg         edge_invert_enable; // Toggle output on valid A edge
  reg         wrap_flag;          // Sticky overflow flag
  reg  [2:0]  capcmp_control;     // Capture/compare use bits
  reg  [7:0]  prescale_edge_control; // Edge selects, clock select
  reg  [2:0]  output_control;     // Enable and match-invert bits
  reg         out_level;          // Timer output flip-flop
  reg         count_new;          // Counter changed last cycle

  // Decoded control
  wire        run;
  wire        clear_mode;
  wire        a_capture;
  wire        b_capture;
  wire        reverse_phase;
  wire        tick;
  wire        a_valid;
  wire        a_opposite;
  wire        b_valid;
  wire        b_unused;
  wire        clear_now;
  wire        cap_a_now;
  wire        cap_b_now;
  wire        match_a;
  wire        match_b;
  wire        irq_a_now;
  wire        irq_b_now;
  wire        toggle_now;
  wire        wrap_now;
  wire        wr_mode;

  assign run           = (op_mode != `MODE_STOP);
  assign clear_mode    = (op_mode == `MODE_CLEAR_START);
  assign a_capture     = capcmp_control[`CC_A_CAPTURE_BIT];
  assign b_capture     = capcmp_control[`CC_B_CAPTURE_BIT];
  assign reverse_phase = capcmp_control[`CC_REVERSE_PHASE_BIT];
  assign wr_mode       = i_wr && (i_addr == `ADDR_OP_MODE_CONTROL);

  // Count clock enable from the divider
  count_prescaler #(
    .DIV1 (DIV1),
    .DIV2 (DIV2),
    .DIV3 (DIV3)
  ) u_prescaler (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_run     (run),
    .i_sel     (prescale_edge_control[`CLK_SEL_MSB:`CLK_SEL_LSB]),
    .o_tick    (tick)
  );

  // Filtered edges of trigger input A
  trig_edge_filter u_trig_a (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_pin      (i_trigger_input_a),
    .i_edge_sel (prescale_edge_control[`TRIG_A_SEL_MSB:`TRIG_A_SEL_LSB]),
    .o_valid    (a_valid),
    .o_opposite (a_opposite)
  );

  // Filtered edges of trigger input B; its opposite edge is unused
  trig_edge_filter u_trig_b (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_pin      (i_trigger_input_b),
    .i_edge_sel (prescale_edge_control[`TRIG_B_SEL_MSB:`TRIG_B_SEL_LSB]),
    .o_valid    (b_valid),
    .o_opposite (b_unused)
  );

  // Valid A edge clears only in clear-and-start mode
  assign clear_now = run && clear_mode && a_valid;

  // Register B captures only from input A
  assign cap_b_now = run && b_capture && a_valid;

  // Register A: opposite A edge or valid B edge
  assign cap_a_now = run && a_capture &&
                     (reverse_phase ? a_opposite : b_valid);

  // Compares look only at a freshly changed count
  assign match_a = run && !a_capture && count_new &&
                   (up_count_value == capture_compare_a);
  assign match_b = run && !b_capture && count_new &&
                   (up_count_value == capture_compare_b);

  // Request A: compare, A capture from a B edge, or bare B edge in reverse phase
  assign irq_a_now = match_a ||
                     (run && a_capture && !reverse_phase && b_valid) ||
                     (run && a_capture && reverse_phase && b_valid);

  // Request B: compare or capture of register B
  assign irq_b_now = match_b || cap_b_now;

  // Output toggles; pin use with B edges is left to software
  assign toggle_now = (edge_invert_enable && run && a_valid) ||
                      (output_control[`OUT_INV_A_BIT] && match_a) ||
                      (output_control[`OUT_INV_B_BIT] && match_b);

  // Overflow on the count clock after FFFF
  assign wrap_now = run && tick && !clear_now &&
                    (up_count_value == `COUNT_FULL);

  assign o_timer_output = output_control[`OUT_ENABLE_BIT] & out_level;

  // Counter: stop clears, edge clear beats the count tick
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      up_count_value <= `COUNT_ZERO;
      count_new      <= 1'b0;
    end else if (!run) begin
      up_count_value <= `COUNT_ZERO;
      count_new      <= 1'b0;
    end else if (clear_now) begin
      // Captures this cycle see the old count
      up_count_value <= `COUNT_ZERO;
      count_new      <= 1'b1;
    end else if (tick) begin
      // Natural 16-bit wrap to zero
      up_count_value <= up_count_value + 16'h0001;
      count_new      <= 1'b1;
    end else begin
      count_new      <= 1'b0;
    end
  end

  // Capture registers; hardware capture wins over a write
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      capture_compare_a <= `RESET_WORD;
      capture_compare_b <= `RESET_WORD;
    end else begin
      if (cap_a_now) begin
        capture_compare_a <= up_count_value;
      end else if (i_wr && i_addr == `ADDR_CAPTURE_COMPARE_A) begin
        capture_compare_a <= i_wdata;
      end
      if (cap_b_now) begin
        capture_compare_b <= up_count_value;
      end else if (i_wr && i_addr == `ADDR_CAPTURE_COMPARE_B) begin
        capture_compare_b <= i_wdata;
      end
    end
  end

  // Control registers written by software
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      op_mode               <= `MODE_STOP;
      edge_invert_enable    <= 1'b0;
      capcmp_control        <= 3'h0;
      prescale_edge_control <= `RESET_BYTE;
      output_control        <= 3'h0;
    end else if (i_wr) begin
      if (i_addr == `ADDR_OP_MODE_CONTROL) begin
        op_mode            <= i_wdata[`MODE_MSB:`MODE_LSB];
        edge_invert_enable <= i_wdata[`EDGE_INVERT_BIT];
      end else if (i_addr == `ADDR_CAPCMP_CONTROL) begin
        capcmp_control <= i_wdata[2:0];
      end else if (i_addr == `ADDR_PRESCALE_EDGE) begin
        prescale_edge_control <= i_wdata[7:0];
      end else if (i_addr == `ADDR_OUTPUT_CONTROL) begin
        output_control <= {i_wdata[`OUT_INV_B_BIT],
                           i_wdata[`OUT_INV_A_BIT],
                           i_wdata[`OUT_ENABLE_BIT]};
      end
    end
  end

  // Wrap flag: a new overflow wins over a clearing write
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wrap_flag <= 1'b0;
    end else if (wrap_now) begin
      wrap_flag <= 1'b1;
    end else if (wr_mode && !i_wdata[`WRAP_FLAG_BIT]) begin
      wrap_flag <= 1'b0;
    end
  end

  // Timer output level and request pulses
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      out_level       <= 1'b0;
      o_irq_request_a <= 1'b0;
      o_irq_request_b <= 1'b0;
    end else begin
      if (!run) begin
        out_level <= 1'b0;
      end else if (toggle_now) begin
        out_level <= ~out_level;
      end
      // One pulse per event; masking lives outside
      o_irq_request_a <= irq_a_now;
      o_irq_request_b <= irq_b_now;
    end
  end

  // Read port; data stand one cycle after the strobe
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_rdata <= `RESET_WORD;
    end else if (i_rd) begin
      if (i_addr == `ADDR_UP_COUNT_VALUE) begin
        o_rdata <= up_count_value;
      end else if (i_addr == `ADDR_CAPTURE_COMPARE_A) begin
        o_rdata <= capture_compare_a;
      end else if (i_addr == `ADDR_CAPTURE_COMPARE_B) begin
        o_rdata <= capture_compare_b;
      end else if (i_addr == `ADDR_OP_MODE_CONTROL) begin
        o_rdata <= {12'h000, op_mode, edge_invert_enable, wrap_flag};
      end else if (i_addr == `ADDR_CAPCMP_CONTROL) begin
        o_rdata <= {13'h0000, capcmp_control};
      end else if (i_addr == `ADDR_PRESCALE_EDGE) begin
        o_rdata <= {8'h00, prescale_edge_control};
      end else if (i_addr == `ADDR_OUTPUT_CONTROL) begin
        o_rdata <= {11'h000, output_control[2], 2'h0,
                    output_control[1], output_control[0]};
      end else begin
        // Unmapped addresses read as zero
        o_rdata <= `RESET_WORD;
      end
    end else begin
      o_rdata <= `RESET_WORD;
    end
  end
endmodule // timer16_edge_clear_freerun
`default_nettype wire

// >>> timer16_defs.vh
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
// Register addresses on the plain register port
`define ADDR_UP_COUNT_VALUE    4'h0
`define ADDR_CAPTURE_COMPARE_A 4'h1
`define ADDR_CAPTURE_COMPARE_B 4'h2
`define ADDR_OP_MODE_CONTROL   4'h3
`define ADDR_CAPCMP_CONTROL    4'h4
`define ADDR_PRESCALE_EDGE     4'h5
`define ADDR_OUTPUT_CONTROL    4'h6
// Operating mode control fields
`define MODE_MSB               3
`define MODE_LSB               2
`define EDGE_INVERT_BIT        1
`define WRAP_FLAG_BIT          0
`define MODE_STOP              2'h0
`define MODE_FREE_RUN          2'h1
`define MODE_CLEAR_START       2'h2
// Capture/compare control fields
`define CC_A_CAPTURE_BIT       0
`define CC_REVERSE_PHASE_BIT   1
`define CC_B_CAPTURE_BIT       2
// Prescale and edge select fields
`define TRIG_B_SEL_MSB         7
`define TRIG_B_SEL_LSB         6
`define TRIG_A_SEL_MSB         5
`define TRIG_A_SEL_LSB         4
`define CLK_SEL_MSB            1
`define CLK_SEL_LSB            0
// Edge select codes
`define EDGE_FALL              2'h0
`define EDGE_RISE              2'h1
`define EDGE_NONE              2'h2
`define EDGE_BOTH              2'h3
// Output control fields
`define OUT_ENABLE_BIT         0
`define OUT_INV_A_BIT          1
`define OUT_INV_B_BIT          4
// Reset values and counter limits
`define RESET_BYTE             8'h00
`define RESET_WORD             16'h0000
`define COUNT_ZERO             16'h0000
`define COUNT_FULL             16'hFFFF
// Count clock dividers
`define DIV_SEL1               4
`define DIV_SEL2               16
`define DIV_SEL3               256
`endif

// >>> trig_edge_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module trig_edge_filter (
  input  wire       i_clk_sys,
  input  wire       i_nrst,
  input  wire       i_pin,
  input  wire [1:0] i_edge_sel,
  output reg        o_valid,
  output reg        o_opposite
);
  reg       sync_1;    // First synchroniser stage
  reg       sync_2;    // Second synchroniser stage
  reg       sample_d;  // Previous sample for the noise filter
  reg       stable;    // Level seen twice in a row
  reg       stable_d;  // Delayed stable level for edge finding
  wire      rise;
  wire      fall;
  assign rise = stable & ~stable_d;
  assign fall = ~stable & stable_d;

  // Sync, two-sample filter, then edge classification
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      sync_1     <= 1'b0;
      sync_2     <= 1'b0;
      sample_d   <= 1'b0;
      stable     <= 1'b0;
      stable_d   <= 1'b0;
      o_valid    <= 1'b0;
      o_opposite <= 1'b0;
    end else begin
      sync_1   <= i_pin;
      sync_2   <= sync_1;
      sample_d <= sync_2;
      // Short glitches never reach the stable level
      if (sync_2 == sample_d) begin
        stable <= sync_2;
      end
      stable_d <= stable;
      case (i_edge_sel)
        `EDGE_FALL: begin
          o_valid    <= fall;
          o_opposite <= rise;
        end
        `EDGE_RISE: begin
          o_valid    <= rise;
          o_opposite <= fall;
        end
        `EDGE_BOTH: begin
          o_valid    <= rise | fall;
          o_opposite <= 1'b0;
        end
        default: begin
          o_valid    <= 1'b0;
          o_opposite <= 1'b0;
        end
      endcase
    end
  end
endmodule // trig_edge_filter
`default_nettype wire

// >>> count_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module count_prescaler #(
  parameter DIV1 = `DIV_SEL1,
  parameter DIV2 = `DIV_SEL2,
  parameter DIV3 = `DIV_SEL3
) (
  input  wire       i_clk_sys,
  input  wire       i_nrst,
  input  wire       i_run,
  input  wire [1:0] i_sel,
  output reg        o_tick
);
  reg  [8:0] div_cnt;  // Free divider count
  reg  [8:0] limit;    // Terminal count for the selected rate
  // Full-width terminal counts; only the low nine bits are used
  localparam [31:0] LIM1 = DIV1 - 1;
  localparam [31:0] LIM2 = DIV2 - 1;
  localparam [31:0] LIM3 = DIV3 - 1;

  // Pick the terminal count
  always @* begin
    case (i_sel)
      2'h0:    limit = 9'h000;
      2'h1:    limit = LIM1[8:0];
      2'h2:    limit = LIM2[8:0];
      default: limit = LIM3[8:0];
    endcase
  end

  // One-cycle tick per count clock; held off while stopped
  always @(posedge i_clk_sys) begin
    if (!i_nrst || !i_run) begin
      div_cnt <= 9'h000;
      o_tick  <= 1'b0;
    end else if (div_cnt >= limit) begin
      div_cnt <= 9'h000;
      o_tick  <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 9'h001;
      o_tick  <= 1'b0;
    end
  end
endmodule // count_prescaler
`default_nettype wire

// >>> timer16_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module timer16_checker #(
  parameter DIV1 = `DIV_SEL1,
  parameter DIV2 = `DIV_SEL2,
  parameter DIV3 = `DIV_SEL3
) (
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_trigger_input_a,
  input wire logic        i_trigger_input_b,
  input wire logic        o_timer_output,
  input wire logic        o_irq_request_a,
  input wire logic        o_irq_request_b
);
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  rdata_idle_a:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
  unmapped_read_a:
    assert property ($past(i_rd) && $past(i_addr) > 4'h6 |-> o_rdata == 16'h0000)
      else $error("unmapped read returned data");
  irq_a_pulse_a:
    assert property (o_irq_request_a |=> !o_irq_request_a)
      else $error("request a longer than one cycle");
  irq_b_pulse_a:
    assert property (o_irq_request_b |=> !o_irq_request_b)
      else $error("request b longer than one cycle");
  reset_quiet_a:
    assert property ($rose(i_nrst) |-> (!o_irq_request_a && !o_irq_request_b) [*3])
      else $error("request right after reset");
  glitch_reject_a:
    assert property ($rose(i_trigger_input_a) ##1 $fell(i_trigger_input_a)
      |-> !o_irq_request_b [*8]) else $error("short pulse accepted");
  out_disable_a:
    assert property ($past(i_wr) && $past(i_addr) == 4'h6 && !$past(i_wdata[0])
      |-> !o_timer_output) else $error("output not off when disabled");
  stop_output_a:
    assert property ($past(i_wr) && $past(i_addr) == 4'h3
      && $past(i_wdata[3:2]) == 2'h0 |-> ##1 !o_timer_output)
      else $error("output not low in stop mode");
endmodule // timer16_checker
bind timer16_edge_clear_freerun timer16_checker #(.DIV1(DIV1), .DIV2(DIV2),
  .DIV3(DIV3)) chk_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_trigger_input_a(i_trigger_input_a),
  .i_trigger_input_b(i_trigger_input_b), .o_timer_output(o_timer_output),
  .o_irq_request_a(o_irq_request_a), .o_irq_request_b(o_irq_request_b));
`default_nettype wire

// >>> trig_pins.sv
`timescale 1ns/1ps
`default_nettype none
module trig_pins (
  input  wire logic i_clk_sys,
  output var  logic o_pin_a,
  output var  logic o_pin_b
);
  // Pins rest low until the bench moves them
  initial begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  end
  // Move one pin after an edge, then hold it for the given number of cycles
  task automatic move(input bit sel, input logic v, input int hold);
    @(posedge i_clk_sys);
    if (sel) o_pin_b <= v;
    else o_pin_a <= v;
    repeat (hold) @(posedge i_clk_sys);
  endtask
  // One-cycle noise spike on pin A
  task automatic spike();
    @(posedge i_clk_sys);
    o_pin_a <= ~o_pin_a;
    @(posedge i_clk_sys);
    o_pin_a <= ~o_pin_a;
  endtask
endmodule // trig_pins
`default_nettype wire

// >>> timer16_edge_clear_freerun_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_edge_clear_freerun_test;
  logic        i_clk_sys = 1'b0; // 100 ns period
  logic        i_nrst    = 1'b0; // Held low for 5 cycles
  logic [3:0]  i_addr    = 4'h0;
  logic [15:0] i_wdata   = 16'h0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  wire  [15:0] o_rdata;
  wire         pin_a, pin_b, o_timer_output, o_irq_request_a, o_irq_request_b;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cyc       = 0; // Cycle stamp for capture expectations
  int          na        = 0; // Request pulses seen
  int          nb        = 0;
  int          h, k, m, t0, t1;
  logic [15:0] v, w, u;
  logic        o0;
  // Clock and event tallies
  always #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (o_irq_request_a === 1'b1) na <= na + 1;
    if (o_irq_request_b === 1'b1) nb <= nb + 1;
  end
  timer16_edge_clear_freerun dut_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_trigger_input_a(pin_a), .i_trigger_input_b(pin_b),
    .o_timer_output(o_timer_output), .o_irq_request_a(o_irq_request_a),
    .o_irq_request_b(o_irq_request_b));
  trig_pins pin_u (.i_clk_sys(i_clk_sys), .o_pin_a(pin_a), .o_pin_b(pin_b));
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Flag widened to a word for the compare task
  function automatic logic [15:0] f(input logic c);
    return {15'h0000, c};
  endfunction
  // Latency of the pin filter blurs captures by a few cycles
  function automatic logic [15:0] near(input logic [15:0] a, input int b);
    int d;
    d = int'(a) - b;
    return f(d <= 6 && d >= -6);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Bounded wait for a new request pulse
  task automatic wait_irq(input bit b, input int bound);
    int base;
    int i;
    base = b ? nb : na;
    for (i = 0; i < bound && (b ? nb : na) == base; i++) idle(1);
    if ((b ? nb : na) == base) begin
      n_errors++;
      results();
    end
  endtask
  initial begin
    v = $urandom(32'h12c5);
    repeat (5) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    // Reset values, unmapped place, read-only count
    for (h = 0; h < 7; h++) begin
      rd(h[3:0], v);
      chk(16'h0000, v);
    end
    u = 16'h0007 + 16'($urandom % 9);
    rd(u[3:0], v);
    chk(16'h0000, v);
    w = 16'($urandom);
    wr(4'h1, w);
    rd(4'h1, v);
    chk(w, v);
    wr(4'h0, 16'h1234);
    rd(4'h0, v);
    chk(16'h0000, v);
    // Clear-start: rise clears, fall captures A, B edge requests A
    wr(4'h5, 16'h0010);
    wr(4'h4, 16'h0003);
    wr(4'h6, 16'h0013);
    wr(4'h2, 16'h0100);
    wr(4'h3, 16'h000A);
    idle(30);
    o0 = o_timer_output;
    m = na;
    t1 = cyc;
    pin_u.move(1'b0, 1'b1, 12);
    rd(4'h0, v);
    chk(16'h0001, f(v < 16'h0010));
    chk(f(!o0), f(o_timer_output));
    idle(20);
    t0 = cyc;
    pin_u.move(1'b0, 1'b0, 12);
    rd(4'h1, v);
    chk(16'h0001, near(v, t0 - t1));
    chk(m[15:0], na[15:0]);
    pin_u.move(1'b1, 1'b1, 12);
    pin_u.move(1'b1, 1'b0, 0);
    wait_irq(1'b0, 20);
    rd(4'h1, w);
    chk(v, w);
    o0 = o_timer_output;
    wait_irq(1'b1, 400);
    rd(4'h0, v);
    chk(16'h0001, f(v >= 16'h0100));
    chk(f(!o0), f(o_timer_output));
    // Both edges of A: capture B, clear, toggle, request B
    wr(4'h5, 16'h0030);
    wr(4'h4, 16'h0005);
    for (h = 0; h < 4; h++) begin
      o0 = o_timer_output;
      k = nb;
      t0 = cyc;
      pin_u.move(1'b0, ~pin_a, 25 + $urandom % 40);
      rd(4'h2, v);
      chk(16'($unsigned(k + 1)), nb[15:0]);
      chk(f(!o0), f(o_timer_output));
      if (h > 0) chk(16'h0001, near(v, t0 - t1));
      t1 = t0;
    end
    // Both edges of B capture A; counter keeps running; output unused
    wr(4'h5, 16'h00C0);
    for (h = 0; h < 3; h++) begin
      k = na;
      t0 = cyc;
      pin_u.move(1'b1, ~pin_b, 20 + $urandom % 40);
      rd(4'h1, v);
      chk(16'($unsigned(k + 1)), na[15:0]);
      if (h > 0) chk(16'h0001, near(v - u, t0 - t1));
      u = v;
      t1 = t0;
    end
    // Pulse width: reverse phase into A, fall into B
    wr(4'h5, 16'h0000);
    wr(4'h4, 16'h0007);
    t1 = cyc;
    pin_u.move(1'b0, 1'b1, 30 + $urandom % 60);
    k = nb;
    m = na;
    t0 = cyc;
    pin_u.move(1'b0, 1'b0, 12);
    chk(16'($unsigned(k + 1)), nb[15:0]);
    chk(m[15:0], na[15:0]);
    rd(4'h1, v);
    rd(4'h2, w);
    chk(16'h0001, near(w - v, t0 - t1));
    rd(4'h0, u);
    chk(16'h0001, f(u < 16'h0020));
    k = nb;
    pin_u.spike();
    idle(15);
    chk(k[15:0], nb[15:0]);
    // Free run with compare A, then wrap
    wr(4'h6, 16'h0012);
    wr(4'h3, 16'h0000);
    rd(4'h0, v);
    chk(16'h0000, v);
    wr(4'h4, 16'h0000);
    w = 16'h1000 + 16'($urandom % 32768);
    wr(4'h1, w);
    wr(4'h3, 16'h0004);
    rd(4'h0, v);
    h = $urandom % 50;
    idle(h);
    rd(4'h0, u);
    chk(16'h0001, near(u - v, h + 2));
    wait_irq(1'b0, 70000);
    rd(4'h0, v);
    chk(16'h0001, f(v > w));
    v = 16'h0000;
    for (k = 0; k < 40000 && !v[0]; k++) rd(4'h3, v);
    chk(16'h0005, v);
    if (!v[0]) results();
    rd(4'h0, u);
    chk(16'h0001, f(u < 16'h0100));
    rd(4'h3, v);
    chk(16'h0005, v);
    wr(4'h3, 16'h0004);
    rd(4'h3, v);
    chk(16'h0004, v);
    results();
  end
endmodule // timer16_edge_clear_freerun_test
`default_nettype wire
